// >>> verilog/wdt_pkg.sv
/*
 * Constants of the watchdog timer: register offsets, field positions,
 * reset values, feed keys and tick divider counts.
 * Assumes an 8-bit register port and one 100 MHz system clock.
 */
package wdt_pkg;

	// Register offsets on the plain register port.
	localparam logic [3:0] WDT_OFS_CONTROL  = 4'h0;
	localparam logic [3:0] WDT_OFS_AUTOLOAD = 4'h1;
	localparam logic [3:0] WDT_OFS_FEED1    = 4'h2;
	localparam logic [3:0] WDT_OFS_FEED2    = 4'h3;
	localparam logic [3:0] WDT_OFS_TICKSEL  = 4'h4;
	localparam logic [3:0] WDT_OFS_COUNT    = 4'h5;

	// Control register field positions.
	localparam int WDT_POS_TAP_HI  = 7;
	localparam int WDT_POS_TAP_LO  = 5;
	localparam int WDT_POS_RUN     = 2;
	localparam int WDT_POS_TOF     = 1;

	// Widths of the prescaler and main counter.
	localparam int WDT_PRE_W = 13;
	localparam int WDT_CNT_W = 8;

	// Values after external reset.
	localparam logic [2:0] WDT_RST_TAP      = 3'h7;
	localparam logic       WDT_RST_RUN      = 1'b1;
	localparam logic       WDT_RST_TOF      = 1'b0;
	localparam logic [7:0] WDT_RST_AUTOLOAD = 8'h00;
	localparam logic [1:0] WDT_RST_TICKSEL  = 2'h0;

	// Feed keys.
	localparam logic [7:0] WDT_FEED1_KEY = 8'hA5;
	localparam logic [7:0] WDT_FEED2_KEY = 8'h5A;

	// Tick divider terminal counts for oscillator divided by 4, 16 and 64.
	localparam logic [5:0] WDT_TICK_TERM_4  = 6'h03;
	localparam logic [5:0] WDT_TICK_TERM_16 = 6'h0F;
	localparam logic [5:0] WDT_TICK_TERM_64 = 6'h3F;

	// Smallest tap: divisor 32 means the low five prescaler bits.
	localparam int WDT_TAP_BASE = 5;

	typedef struct packed {
		logic [5:0]           tick_cnt;
		logic [1:0]           tick_sel;
		logic [WDT_PRE_W-1:0] prescaler;
		logic [WDT_CNT_W-1:0] counter;
		logic [7:0]           autoload;
		logic [2:0]           tap;
		logic                 run;
		logic                 tof;
		logic [2:0]           pend_tap;
		logic                 pend_run;
		logic                 armed;
		logic                 wdt_reset;
		logic [7:0]           rd_data;
	} wdt_state_s;

endpackage

// >>> verilog/wdt_top.sv
/*
 * Watchdog timer: tick divider, 13-bit prescaler, 8-bit main down-counter,
 * autoload register, two-step feed check and pending control register.
 * Assumes a register master that keeps the strobe timing of a plain port
 * and that reports other peripheral register accesses on other_access.
 */
`timescale 1ns/1ps

// What this block does
// - Watchdog runs after external reset; software must switch it off.
// - A 13-bit prescaler feeds an 8-bit main down-counter.
// - Prescaler advances on the shared timer tick, not the oscillator.
// - Main counter decrements once per pulse of the selected upper tap.
// - Tap codes 000 to 111 give divisors 32 up to 4096, doubling.
// - Decrement at zero is an underflow and reloads from autoload.
// - Every autoload clears the prescaler, so any autoload value works.
// - Software writes only the autoload value; a feed moves it inward.
// - Feed is A5 to first feed register then 5A to second, next access.
// - Correct first feed and wrong second feed reset at once.
// - Any other register access between feed writes causes a reset.
// - Control tap and run writes stay pending until a valid feed completes; flag clear is immediate.
// - Reset values give a running watchdog with the longest tap.
// - External reset sets run, autoload 00, clears flag and prescaler.
// - External reset wins over a coincident underflow; flag cleared.
// - Underflow autoloads, sets flag, keeps settings, resets the device.
// - Timeout flag survives watchdog reset and software can clear it.
// - Control holds tap at 7 to 5, run at 2, flag at 1.
// - Timer tick is oscillator over 4, 16 or 64 by a two-bit field.
module wdt_top
	import wdt_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wr_data,
	input  wire logic              wr_strobe,
	input  wire logic              rd_strobe,
	input  wire logic              other_access,
	output logic [7:0]             rd_data,
	output logic                   wdt_reset,
	output logic                   timeout_flag
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks.

	if (ADDR_W < 3) begin : g_bad_addr
		$error("ADDR_W must be at least 3.");
	end

	////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Terminal count of the tick divider; the reserved code acts as 64.
	function automatic logic [5:0] tick_term(input logic [1:0] sel);
		logic [5:0] t;
		t = WDT_TICK_TERM_64;
		case (sel)
			2'h0: t = WDT_TICK_TERM_4;
			2'h1: t = WDT_TICK_TERM_16;
			2'h2: t = WDT_TICK_TERM_64;
			default: t = WDT_TICK_TERM_64;
		endcase
		return t;
	endfunction

	// Mask of prescaler bits below the selected tap.
	function automatic logic [WDT_PRE_W-1:0] tap_mask(input logic [2:0] tap);
		logic [WDT_PRE_W-1:0] m;
		m = '0;
		for (int i = 0; i < WDT_PRE_W; i++) begin
			if (i < WDT_TAP_BASE + int'(tap)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	// Register offset compare with address and offset both widened to ADDR_W+4 bits.
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [3:0] ofs);
		logic [ADDR_W+3:0] wa;
		logic [ADDR_W+3:0] wo;
		wa = {4'h0, a};
		wo = {{ADDR_W{1'b0}}, ofs};
		return wa == wo;
	endfunction

	// Decrement pulse: the prescaler bits below the tap are all ones.
	function automatic logic dec_due(input logic [WDT_PRE_W-1:0] pre,
		input logic [2:0] tap);
		logic [WDT_PRE_W-1:0] m;
		m = tap_mask(tap);
		return (pre & m) == m;
	endfunction

	// Write data carrying the expected feed key.
	function automatic logic key_match(input logic [7:0] d,
		input logic [7:0] key);
		return d == key;
	endfunction

	// Read image of the control register.
	function automatic logic [7:0] ctrl_image(input logic [2:0] tap,
		input logic run, input logic tof);
		logic [7:0] img;
		img = 8'h00;
		img[WDT_POS_TAP_HI:WDT_POS_TAP_LO] = tap;
		img[WDT_POS_RUN] = run;
		img[WDT_POS_TOF] = tof;
		return img;
	endfunction

	// True when every register offset is distinct and fits the address.
	function automatic logic map_ok();
		logic [3:0] ofs [6];
		logic       ok;
		ofs[0] = WDT_OFS_CONTROL;
		ofs[1] = WDT_OFS_AUTOLOAD;
		ofs[2] = WDT_OFS_FEED1;
		ofs[3] = WDT_OFS_FEED2;
		ofs[4] = WDT_OFS_TICKSEL;
		ofs[5] = WDT_OFS_COUNT;
		ok = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (int'(ofs[i]) >= (1 << ADDR_W)) begin
				ok = 1'b0;
			end
			for (int j = i + 1; j < 6; j++) begin
				if (ofs[i] == ofs[j]) begin
					ok = 1'b0;
				end
			end
		end
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks on the register map, the counter chain, the feed keys and the reset values.

	if (!map_ok()) begin : g_bad_map
		$error("Register offsets must be distinct and fit ADDR_W.");
	end

	if (ADDR_W > 8) begin : g_wide_addr
		$error("ADDR_W must be at most 8.");
	end

	if (WDT_PRE_W < WDT_TAP_BASE + 7) begin : g_bad_pre
		$error("Prescaler too narrow for eight taps.");
	end

	if (WDT_CNT_W != 8) begin : g_bad_cnt
		$error("Main counter must be eight bits wide.");
	end

	if (WDT_TAP_BASE < 1) begin : g_bad_base
		$error("Tap base must be at least one.");
	end

	if (WDT_TICK_TERM_4 >= WDT_TICK_TERM_16) begin : g_bad_term16
		$error("Tick terminal counts must rise with the divisor.");
	end

	if (WDT_TICK_TERM_16 >= WDT_TICK_TERM_64) begin : g_bad_term64
		$error("Tick terminal counts must rise with the divisor.");
	end

	if (WDT_POS_TAP_HI - WDT_POS_TAP_LO != 2) begin : g_bad_tapf
		$error("Tap field must be three bits wide.");
	end

	if (WDT_POS_RUN == WDT_POS_TOF) begin : g_bad_flags
		$error("Run bit and timeout flag must differ in position.");
	end

	if (WDT_FEED1_KEY == WDT_FEED2_KEY) begin : g_bad_keys
		$error("The two feed keys must differ.");
	end

	if (WDT_RST_TAP != 3'h7) begin : g_bad_rtap
		$error("Reset tap must select the largest divisor.");
	end

	if (WDT_RST_RUN != 1'b1) begin : g_bad_rrun
		$error("The watchdog must run after reset.");
	end

	if (WDT_RST_AUTOLOAD != 8'h00) begin : g_bad_rload
		$error("Reset autoload value must be zero.");
	end

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.

	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state.

	wdt_state_s s;
	wdt_state_s next_s;

	logic tick;
	logic dec;
	logic underflow;
	logic access;
	logic feed_ok;
	logic feed_bad;
	logic wd_reset;
	logic own_wr;
	logic sel_ctrl;
	logic sel_auto;
	logic sel_feed1;
	logic sel_feed2;
	logic sel_tick;

	always_comb begin
		next_s = s;
		next_s.wdt_reset = 1'b0;
		next_s.rd_data = 8'h00;

		// Timer tick from the oscillator.
		tick = (s.tick_cnt >= tick_term(s.tick_sel));
		next_s.tick_cnt = tick ? 6'h00 : s.tick_cnt + 6'h01;

		// Prescaler and main counter advance only while running.
		dec = 1'b0;
		if (s.run && tick) begin
			next_s.prescaler = s.prescaler + 13'h0001;
			dec = dec_due(s.prescaler, s.tap);
		end
		underflow = dec && (s.counter == 8'h00);
		if (dec) begin
			next_s.counter = s.counter - 8'h01;
		end

		// Register decode shared by the feed check and the writes.
		own_wr    = wr_strobe && !other_access;
		sel_ctrl  = hit(addr, WDT_OFS_CONTROL);
		sel_auto  = hit(addr, WDT_OFS_AUTOLOAD);
		sel_feed1 = hit(addr, WDT_OFS_FEED1);
		sel_feed2 = hit(addr, WDT_OFS_FEED2);
		sel_tick  = hit(addr, WDT_OFS_TICKSEL);

		// Feed check on every register access.
		access = wr_strobe || rd_strobe || other_access;
		feed_ok = s.armed && own_wr && sel_feed2
			&& key_match(wr_data, WDT_FEED2_KEY);
		feed_bad = s.armed && access && !feed_ok;
		if (access) begin
			next_s.armed = !s.armed && own_wr && sel_feed1
				&& key_match(wr_data, WDT_FEED1_KEY);
		end

		// Register writes; the counter has no write path.
		if (own_wr) begin
			if (sel_ctrl) begin
				next_s.pend_tap = wr_data[WDT_POS_TAP_HI:WDT_POS_TAP_LO];
				next_s.pend_run = wr_data[WDT_POS_RUN];
				if (!wr_data[WDT_POS_TOF]) begin
					next_s.tof = 1'b0;
				end
			end
			if (sel_auto) begin
				next_s.autoload = wr_data;
			end
			if (sel_tick) begin
				next_s.tick_sel = wr_data[1:0];
			end
		end

		// A valid feed applies the pending control and autoloads.
		if (feed_ok) begin
			next_s.tap = s.pend_tap;
			next_s.run = s.pend_run;
		end

		// Underflow or a broken feed is a watchdog reset; settings stay.
		wd_reset = underflow || feed_bad;
		if (wd_reset) begin
			next_s.tof = 1'b1;
			next_s.wdt_reset = 1'b1;
			next_s.armed = 1'b0;
		end
		if (feed_ok || wd_reset) begin
			next_s.counter = s.autoload;
			next_s.prescaler = '0;
		end

		// Read data appear in the cycle after the strobe.
		if (rd_strobe) begin
			if (hit(addr, WDT_OFS_CONTROL)) begin
				next_s.rd_data = ctrl_image(s.tap, s.run, s.tof);
			end
			if (hit(addr, WDT_OFS_AUTOLOAD)) begin
				next_s.rd_data = s.autoload;
			end
			if (hit(addr, WDT_OFS_TICKSEL)) begin
				next_s.rd_data[1:0] = s.tick_sel;
			end
			if (hit(addr, WDT_OFS_COUNT)) begin
				next_s.rd_data = s.counter;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; external reset wins over any underflow.

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s.tick_cnt  <= 6'h00;
			s.tick_sel  <= WDT_RST_TICKSEL;
			s.prescaler <= '0;
			s.counter   <= WDT_RST_AUTOLOAD;
			s.autoload  <= WDT_RST_AUTOLOAD;
			s.tap       <= WDT_RST_TAP;
			s.run       <= WDT_RST_RUN;
			s.tof       <= WDT_RST_TOF;
			s.pend_tap  <= WDT_RST_TAP;
			s.pend_run  <= WDT_RST_RUN;
			s.armed     <= 1'b0;
			s.wdt_reset <= 1'b0;
			s.rd_data   <= 8'h00;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data      = s.rd_data;
	assign wdt_reset    = s.wdt_reset;
	assign timeout_flag = s.tof;

endmodule // wdt_top

// >>> tb/wdt_chk.sv
/* Port checker of the watchdog timer.
   Assumes wdt_top and its package; bound below. */
`timescale 1ns/1ps
module wdt_chk
	import wdt_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input wire logic              clk_sys,
	input wire logic              rst_b,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0]        wr_data,
	input wire logic              wr_strobe,
	input wire logic              rd_strobe,
	input wire logic              other_access,
	input wire logic [7:0]        rd_data,
	input wire logic              wdt_reset,
	input wire logic              timeout_flag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_arm;
		wr_strobe && !other_access && addr == WDT_OFS_FEED1
			&& wr_data == WDT_FEED1_KEY;
	endsequence
	sequence s_break;
		rd_strobe || other_access || (wr_strobe
			&& !(addr == WDT_OFS_FEED2 && wr_data == WDT_FEED2_KEY));
	endsequence
	sequence s_ld;
		wr_strobe && !other_access && addr == WDT_OFS_AUTOLOAD;
	endsequence
	////////////////////////////////////////
	AST_BAD_FEED: assert property (s_arm ##1 s_break |=> wdt_reset)
		else $error("bad feed gave no reset");
	AST_PULSE: assert property (wdt_reset |=> !wdt_reset)
		else $error("reset pulse too long");
	AST_FLAG_SET: assert property (wdt_reset |-> timeout_flag)
		else $error("reset without flag");
	AST_FLAG_CAUSE: assert property ($rose(timeout_flag) |-> wdt_reset)
		else $error("flag rose without reset");
	AST_FLAG_HOLD: assert property (timeout_flag && !(wr_strobe
		&& addr == WDT_OFS_CONTROL && !wr_data[1]) |=> timeout_flag)
		else $error("flag lost");
	AST_CTRL_RD: assert property (rd_strobe && addr == WDT_OFS_CONTROL
		|=> rd_data[1] == $past(timeout_flag) && rd_data[4:3] == 2'h0)
		else $error("control read wrong");
	AST_AUTO_RB: assert property (s_ld ##1 rd_strobe
		&& addr == WDT_OFS_AUTOLOAD |=> rd_data == $past(wr_data, 2))
		else $error("autoload readback wrong");
	AST_RD_IDLE: assert property (!$past(rd_strobe) |-> rd_data == 8'h00)
		else $error("read data outside its cycle");
endmodule // wdt_chk
bind wdt_top wdt_chk #(.ADDR_W(ADDR_W)) wdt_chk_inst (.clk_sys, .rst_b,
	.addr, .wr_data, .wr_strobe, .rd_strobe, .other_access, .rd_data,
	.wdt_reset, .timeout_flag);

// >>> tb/wdt_top_tb.sv
/* Self-checking bench of the watchdog timer.
   Assumes wdt_top, its package and the bound checker. */
`timescale 1ns/1ps
module wdt_top_tb
	import wdt_pkg::*;
;
	logic       clk_sys = 1'b0;
	logic       rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic       wr_strobe = 1'b0;
	logic       rd_strobe = 1'b0;
	logic       other_access = 1'b0;
	logic [7:0] rd_data, d, v;
	logic       wdt_reset, timeout_flag;
	int         miscompares = 0, checked = 0, n, t, s, w, e;
	always #5 clk_sys = ~clk_sys;
	wdt_top wdt_top_inst (.clk_sys, .rst_b, .addr, .wr_data, .wr_strobe,
		.rd_strobe, .other_access, .rd_data, .wdt_reset, .timeout_flag);
	////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		wr_strobe <= 1'b1;
		rd_strobe <= 1'b0;
		addr <= a;
		wr_data <= x;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a);
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_strobe <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic idle(input int c);
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b0;
		other_access <= 1'b0;
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic feed();
		wr(WDT_OFS_FEED1, WDT_FEED1_KEY);
		wr(WDT_OFS_FEED2, WDT_FEED2_KEY);
		idle(1);
	endtask
	task automatic wait_rst(input int lim);
		idle(0);
		n = 0;
		#1;
		while (wdt_reset !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			#1 n++;
		end
		if (n >= lim) begin
			miscompares++;
			close_out();
		end
	endtask
	function automatic int tick_div(input int sel);
		return sel > 2 ? 64 : 4 << (2 * sel);
	endfunction
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h1B3B));
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(WDT_OFS_CONTROL);
		chk("control", d, 8'hE4);
		rd(WDT_OFS_AUTOLOAD);
		chk("autoload", d, 8'h00);
		rd(4'hF);
		chk("unmapped", d, 8'h00);
		v = 8'($urandom_range(200, 20));
		wr(WDT_OFS_AUTOLOAD, v);
		wr(WDT_OFS_COUNT, 8'hFF);
		rd(WDT_OFS_AUTOLOAD);
		chk("autoload", d, v);
		rd(WDT_OFS_COUNT);
		chk("count", d, 8'h00);
		wr(WDT_OFS_CONTROL, 8'h00);
		rd(WDT_OFS_CONTROL);
		chk("pending", d, 8'hE4);
		feed();
		rd(WDT_OFS_CONTROL);
		chk("control", d, 8'h00);
		idle(300);
		rd(WDT_OFS_COUNT);
		chk("stopped", d, v);
		wr(WDT_OFS_FEED1, 8'h3C);
		rd(WDT_OFS_COUNT);
		idle(6);
		chk("no reset", timeout_flag, 1'b0);
		for (int k = 0; k < 3; k++) begin
			wr(WDT_OFS_FEED1, WDT_FEED1_KEY);
			if (k == 0) wr(WDT_OFS_FEED2, 8'h55);
			else if (k == 1) rd(WDT_OFS_AUTOLOAD);
			else begin
				wr_strobe <= 1'b0;
				other_access <= 1'b1;
				@(posedge clk_sys);
			end
			wait_rst(4);
			chk("flag", timeout_flag, 1'b1);
			rd(WDT_OFS_CONTROL);
			chk("control", d, 8'h02);
			rd(WDT_OFS_COUNT);
			chk("reload", d, v);
			wr(WDT_OFS_CONTROL, 8'h00);
			idle(1);
			#1 chk("cleared", timeout_flag, 1'b0);
		end
		for (int i = 0; i < 11; i++) begin
			t = i < 8 ? i : 0;
			s = i < 8 ? 0 : i - 7;
			w = i < 8 ? 0 : $urandom_range(3, 0);
			wr(WDT_OFS_TICKSEL, 8'(s));
			wr(WDT_OFS_AUTOLOAD, 8'(w));
			wr(WDT_OFS_CONTROL, {3'(t), 5'h04});
			feed();
			e = tick_div(s) * (32 << t) * (w + 1);
			wait_rst(e + 100);
			chk("timeout", n + tick_div(s) + 4 >= e && n <= e + 68, 1);
		end
		close_out();
	end
endmodule // wdt_top_tb
